// File: hdl/interrupt_priority_enable_bank.sv
// Interrupt priority and ADC pair enable bank, reached over AXI4-Lite.
// Assumes the flag registers and the arbiter sit elsewhere and read the
// per-source pass and level outputs; all inputs are on CLK_I.
// Handshake outputs are registered; the master may wait any number of cycles.
// The bus master shares CLK_I, so no bus input is synchronised.
`timescale 1ns/1ps

// Summary of operation
// - An enable bit of 1 lets that source's request pass, 0 blocks it.
// - Priority code 111 gives level 7, the highest level.
// - Code 001 gives level 1 and codes between map straight to levels 2 to 6.
// - Code 000 blocks the source completely whatever its enable bit.
// - Unimplemented bits read as zero and ignore writes.
// - Pin-change register holds pin change, comparator1, i2c master, i2c slave at 14-12 down to 2-0.
// - External line 1 priority sits at bits 2-0 with bits 15-3 unused.
// - External line 2 priority sits at bits 6-4 with the rest unused.
module interrupt_priority_enable_bank
    import prio_bank_pkg::*;
(
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RESETN_I,
    // AXI4-Lite write address and data
    input  wire logic [5:0]             S_AXI_AWADDR_I,
    input  wire logic                   S_AXI_AWVALID_I,
    output logic                        S_AXI_AWREADY_O,
    input  wire logic [31:0]            S_AXI_WDATA_I,
    input  wire logic [3:0]             S_AXI_WSTRB_I,
    input  wire logic                   S_AXI_WVALID_I,
    output logic                        S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]                  S_AXI_BRESP_O,
    output logic                        S_AXI_BVALID_O,
    input  wire logic                   S_AXI_BREADY_I,
    // AXI4-Lite read
    input  wire logic [5:0]             S_AXI_ARADDR_I,
    input  wire logic                   S_AXI_ARVALID_I,
    output logic                        S_AXI_ARREADY_O,
    output logic [31:0]                 S_AXI_RDATA_O,
    output logic [1:0]                  S_AXI_RRESP_O,
    output logic                        S_AXI_RVALID_O,
    input  wire logic                   S_AXI_RREADY_I,
    // Per-source results toward the arbiter
    output logic [NUM_SRC-1:0]          SRC_PASS_O,
    output logic [NUM_SRC*3-1:0]        SRC_LEVEL_O,
    // Bus error interrupt
    output logic                        IRQ_O
);

    // Registered state and its next value
    bank_state_t st;
    bank_state_t next_st;

    // Source index map (index = 4 * register + field, field 0 at bits 2-0)
    // Pass is 1 when the source may request; level is its raw code
    //  0: ext line 0
    //  1: capture 1
    //  2: compare 1
    //  3: timer 1
    //  4: unused, always blocked
    //  5: capture 2
    //  6: compare 2
    //  7: timer 2
    //  8: timer 3
    //  9: sync serial error
    // 10: sync serial event
    // 11: serial receive
    // 12: serial transmit
    // 13: ADC done
    // 14: ext line 2, moved into this unused slot
    // 15: unused, always blocked
    // 16: i2c slave events
    // 17: i2c master events
    // 18: comparator 1
    // 19: pin change
    // 20: ext line 1
    // 21 to 25: ADC pairs 2 to 6, at the ADC done level
    // Unused slots stay blocked because their implemented flag is 0

    // Implemented-bit mask of each priority register
    // Index order: timer1, timer2, serial rx, ADC, pin change, ext 1, ext 2
    function automatic logic [15:0] pri_mask(input int idx);
        case (idx)
            1:       pri_mask = MASK_T2;
            3:       pri_mask = MASK_ADC;
            5:       pri_mask = MASK_EXT1;
            6:       pri_mask = MASK_EXT2;
            default: pri_mask = MASK_FOUR;
        endcase
    endfunction

    // Index of a priority register from its byte offset, or -1
    // Offsets 0x04 to 0x1C give indices 0 to 6
    // Upper address bit 5 is covered by the range test
    function automatic int pri_index(input logic [5:0] ofs);
        if (ofs >= OFS_PRI_T1 && ofs <= OFS_PRI_EXT2) begin
            pri_index = int'(ofs[4:2]) - 1;
        end else begin
            pri_index = -1;
        end
    endfunction

    // Source slot of a field of a priority register
    function automatic int src_index(input int r, input int f);
        src_index = r*4 + f;
    endfunction

    // A source may request only when enabled, implemented and not at code 000
    // Unimplemented fields pass an implemented flag of 0
    function automatic logic pass_of(input logic [2:0] code, input logic en, input logic impl);
        pass_of = en && impl && (code != PRI_OFF);
    endfunction

    // Whether a write offset names a register of this bank
    // Status is mapped: it takes the write and drops it
    function automatic logic wr_mapped(input logic [5:0] ofs);
        wr_mapped = 1'b0;
        if (ofs[1:0] == 2'h0) begin
            if (ofs == OFS_ADC_EN || pri_index(ofs) >= 0) begin
                wr_mapped = 1'b1;
            end else if (ofs == OFS_INT_STAT || ofs == OFS_INT_CLR || ofs == OFS_INT_EN) begin
                wr_mapped = 1'b1;
            end
        end
    endfunction

    // Merge a write into a 16-bit register under strobes and mask
    // Strobes 2 and 3 cover only bits that read as zero, so they are ignored
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        merge = v & m;
    endfunction

    // Readback of any offset
    // Bit 32 flags a misaligned or unmapped offset, answered with an error
    function automatic logic [32:0] read_word(input bank_state_t s, input logic [5:0] ofs);
        int i;
        i = pri_index(ofs);
        read_word = {1'b0, 32'h00000000};
        if (ofs[1:0] != 2'h0) begin
            read_word = {1'b1, 32'h00000000};
        end else if (ofs == OFS_ADC_EN) begin
            read_word = {1'b0, 27'h0, s.adc_en};
        end else if (i >= 0) begin
            read_word = {1'b0, 16'h0, s.pri[i] & pri_mask(i)};
        end else if (ofs == OFS_INT_STAT) begin
            read_word = {1'b0, 30'h0, s.int_stat};
        end else if (ofs == OFS_INT_EN) begin
            read_word = {1'b0, 30'h0, s.int_en};
        end else if (ofs == OFS_INT_CLR) begin
            read_word = {1'b0, 32'h00000000};
        end else begin
            read_word = {1'b1, 32'h00000000};
        end
    endfunction

    // Next-state logic: bus slave, register file, source gating
    always_comb begin
        // Working values; each is given a default first so no latch is inferred
        logic        wr_fire;
        logic        wr_ok;
        logic        rd_err;
        logic [32:0] rw;
        logic [1:0]  set_ev;
        logic [1:0]  clr_ev;
        logic [15:0] en_word;
        logic [2:0]  code;
        logic        en_bit;
        int          wi;
        logic [15:0] msk;
        next_st = st;
        wr_fire = 1'b0;
        wr_ok   = 1'b1;
        rd_err  = 1'b0;
        rw      = 33'h0;
        set_ev  = 2'h0;
        clr_ev  = 2'h0;
        en_word = 16'h0;
        code    = 3'h0;
        en_bit  = 1'b0;
        wi      = -1;
        msk     = 16'h0;

        // Write channel: take address and data in either order
        // Capture follows the registered readies, so every take is seen by the master
        if (S_AXI_AWVALID_I && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = S_AXI_WDATA_I;
            next_st.w_strb = S_AXI_WSTRB_I;
        end
        // The hold state leaves one idle cycle after each response
        unique case (st.wr_state)
            WR_IDLE: begin
                if (st.aw_got && st.w_got) begin
                    wr_fire = 1'b1;
                    next_st.wr_state = WR_RESP;
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY_I) begin
                    next_st.wr_state = WR_HOLD;
                end
            end
            WR_HOLD: begin
                next_st.wr_state = WR_IDLE;
            end
        endcase

        // Register update on a complete write
        // A refused write changes nothing and sets the write error bit
        if (wr_fire) begin
            wi = pri_index(st.aw_addr);
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            wr_ok = wr_mapped(st.aw_addr);
            if (!wr_ok) begin
                en_word = 16'h0;
            end else if (st.aw_addr == OFS_ADC_EN) begin
                en_word = merge({11'h0, st.adc_en}, st.w_data, st.w_strb, ADC_EN_MASK);
                next_st.adc_en = en_word[4:0];
            end else if (wi >= 0) begin
                next_st.pri[wi] = merge(st.pri[wi], st.w_data, st.w_strb, pri_mask(wi));
            end else if (st.aw_addr == OFS_INT_CLR) begin
                if (st.w_strb[0]) begin
                    clr_ev = st.w_data[1:0];
                end
            end else if (st.aw_addr == OFS_INT_EN) begin
                if (st.w_strb[0]) begin
                    next_st.int_en = st.w_data[1:0];
                end
            end
            next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            set_ev[EVT_WR_ERR] = !wr_ok;
        end

        // Read channel: one-cycle address accept, data held until rready
        // Read data comes from the state before this edge's write lands
        unique case (st.rd_state)
            RD_IDLE: begin
                if (S_AXI_ARVALID_I && st.arready) begin
                    rw = read_word(st, S_AXI_ARADDR_I);
                    rd_err = rw[32];
                    next_st.rdata = rw[31:0];
                    next_st.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
                    next_st.rd_state = RD_DATA;
                end
            end
            RD_DATA: begin
                if (S_AXI_RREADY_I) begin
                    next_st.rd_state = RD_IDLE;
                end
            end
        endcase
        set_ev[EVT_RD_ERR] = rd_err;

        // Sticky status: a new event wins over a clear
        // Status is read-only; only the clear register lowers its bits
        next_st.int_stat = (st.int_stat & ~clr_ev) | set_ev;
        // Interrupt follows the next status so it rises with the event
        next_st.irq = |(next_st.int_stat & next_st.int_en);

        // Per-source pass and level; level equals the 3-bit code
        // Slots past the last source are dropped by the range test
        for (int r = 0; r < NUM_PRI_REGS; r++) begin
            msk = pri_mask(r);
            for (int f = 0; f < 4; f++) begin
                code = next_st.pri[r][f*4 +: 3];
                en_bit = 1'b1;                      // Only ADC pairs have enables here
                if (src_index(r, f) < NUM_SRC) begin
                    next_st.src_level[src_index(r, f)] = code;
                    next_st.src_pass[src_index(r, f)]  = pass_of(code, en_bit, msk[f*4]);
                end
            end
        end
        // ADC pair sources follow their enable bits at the ADC done level
        // Their slots reuse unused fields and the ext line 2 slot
        code = next_st.pri[3][6:4];
        for (int p = 0; p < 5; p++) begin
            next_st.src_level[21 + p] = code;
            next_st.src_pass[21 + p]  = pass_of(code, next_st.adc_en[p], 1'b1);
        end
        // Ext line 2 would collide with pair 6, so it moves to unused slot 14
        // Slot 14 is the unimplemented third field (bits 10-8) of the ADC register
        code = next_st.pri[6][6:4];
        next_st.src_level[14] = code;
        next_st.src_pass[14]  = pass_of(code, 1'b1, 1'b1);

        // Handshake outputs registered from the next state, so each pin is a flop
        // They match the state decode in the same cycle at no extra latency
        next_st.awready = next_st.wr_state == WR_IDLE && !next_st.aw_got;
        next_st.wready  = next_st.wr_state == WR_IDLE && !next_st.w_got;
        next_st.bvalid  = next_st.wr_state == WR_RESP;
        next_st.arready = next_st.rd_state == RD_IDLE;
        next_st.rvalid  = next_st.rd_state == RD_DATA;

        // Reset values
        // Readies stay low until the first edge after release
        if (!RESETN_I) begin
            next_st = '0;
            next_st.wr_state = WR_IDLE;
            next_st.rd_state = RD_IDLE;
            next_st.adc_en = 5'h00;
            for (int r = 0; r < NUM_PRI_REGS; r++) begin
                next_st.pri[r] = PRI_RST_WORD & pri_mask(r);
            end
        end
    end

    // State register
    // Reset is synchronous, so it is folded into the next-state logic
    always_ff @(posedge CLK_I) begin
        st <= next_st;
    end

    // Bus handshakes and answers, straight from flip-flops
    assign S_AXI_AWREADY_O = st.awready;
    assign S_AXI_WREADY_O  = st.wready;
    assign S_AXI_BVALID_O  = st.bvalid;
    assign S_AXI_BRESP_O   = st.bresp;
    assign S_AXI_ARREADY_O = st.arready;
    assign S_AXI_RVALID_O  = st.rvalid;
    assign S_AXI_RDATA_O   = st.rdata;
    assign S_AXI_RRESP_O   = st.rresp;

    // Source results and interrupt, straight from flip-flops
    assign SRC_PASS_O      = st.src_pass;
    assign SRC_LEVEL_O     = st.src_level;
    assign IRQ_O           = st.irq;

endmodule

// File: hdl/prio_bank_pkg.sv
// Package for the interrupt priority and enable bank.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package prio_bank_pkg;

    // Register byte offsets
    localparam logic [5:0] OFS_ADC_EN     = 6'h00;
    localparam logic [5:0] OFS_PRI_T1     = 6'h04;
    localparam logic [5:0] OFS_PRI_T2     = 6'h08;
    localparam logic [5:0] OFS_PRI_RX     = 6'h0C;
    localparam logic [5:0] OFS_PRI_ADC    = 6'h10;
    localparam logic [5:0] OFS_PRI_CN     = 6'h14;
    localparam logic [5:0] OFS_PRI_EXT1   = 6'h18;
    localparam logic [5:0] OFS_PRI_EXT2   = 6'h1C;
    localparam logic [5:0] OFS_INT_STAT   = 6'h20;
    localparam logic [5:0] OFS_INT_CLR    = 6'h24;
    localparam logic [5:0] OFS_INT_EN     = 6'h28;

    // Register counts and field layout
    localparam int         NUM_PRI_REGS   = 7;
    localparam int         NUM_SRC        = 26;
    localparam logic [2:0] PRI_RESET      = 3'h4;
    localparam logic [2:0] PRI_OFF        = 3'h0;
    localparam logic [15:0] ADC_EN_MASK   = 16'h001F;
    localparam logic [15:0] MASK_FOUR     = 16'h7777;
    localparam logic [15:0] MASK_T2       = 16'h7770;
    localparam logic [15:0] MASK_ADC      = 16'h0077;
    localparam logic [15:0] MASK_EXT1     = 16'h0007;
    localparam logic [15:0] MASK_EXT2     = 16'h0070;
    localparam logic [15:0] PRI_RST_WORD  = 16'h4444;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Interrupt status bits: bus error events of this bank
    localparam int         EVT_WR_ERR     = 0;
    localparam int         EVT_RD_ERR     = 1;

    // Bus state machines
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

    // Whole module state
    typedef struct packed {
        wr_state_t          wr_state;
        rd_state_t          rd_state;
        logic               aw_got;
        logic               w_got;
        logic [5:0]         aw_addr;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic [1:0]         bresp;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [4:0]         adc_en;
        logic [NUM_PRI_REGS-1:0][15:0] pri;
        logic [1:0]         int_stat;
        logic [1:0]         int_en;
        logic               irq;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic               arready;
        logic               rvalid;
        logic [NUM_SRC-1:0] src_pass;
        logic [NUM_SRC-1:0][2:0] src_level;
    } bank_state_t;

endpackage

// File: verification/interrupt_priority_enable_bank_tb.sv
// Self-checking bench for the priority bank over AXI4-Lite.
// Assumes the bank, its package, the checker and the arbiter model are compiled first.
`timescale 1ns/1ps
module interrupt_priority_enable_bank_tb
    import prio_bank_pkg::*;
;
    logic                 clk = 1'b0, resetn = 1'b0;
    logic [5:0]           awaddr = '0, araddr = '0;
    logic                 awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0]          wdata = '0, rdata;
    logic                 awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]           bresp, rresp, r;
    logic [NUM_SRC-1:0]   pass;
    logic [NUM_SRC*3-1:0] level;
    logic [2:0]           top;
    logic [31:0]          d;
    int                   n_errors = 0, tests_run = 0, cycles = 0;
    logic [5:0]  ofs [8] = '{OFS_ADC_EN, OFS_PRI_T1, OFS_PRI_T2, OFS_PRI_RX,
                             OFS_PRI_ADC, OFS_PRI_CN, OFS_PRI_EXT1, OFS_PRI_EXT2};
    logic [15:0] msk [8] = '{ADC_EN_MASK, MASK_FOUR, MASK_T2, MASK_FOUR,
                             MASK_ADC, MASK_FOUR, MASK_EXT1, MASK_EXT2};

    interrupt_priority_enable_bank interrupt_priority_enable_bank_i (
        .CLK_I(clk), .RESETN_I(resetn), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .SRC_PASS_O(pass), .SRC_LEVEL_O(level), .IRQ_O(irq));
    prio_arbiter_model prio_arbiter_model_i (.pass_i(pass), .level_i(level), .top_o(top));

    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write: address and data offered together, each released when taken
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
            if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        rd(a);
        chk("read data", exp, d);
        chk("read resp", RESP_OKAY, r);
    endtask

    task t_reset;
        for (int i = 0; i < 8; i++) rchk(ofs[i], i ? PRI_RST_WORD & msk[i] : 16'h0);
        chk("pass0", 1, pass[0]);
        chk("level0", 4, level[2:0]);
        chk("adc pass", 0, pass[25:21]);
        $display("t_reset done");
    endtask

    task t_masks;
        for (int i = 0; i < 8; i++) begin
            wr(ofs[i], 32'hFFFFFFFF);
            rchk(ofs[i], msk[i]);
            wr(ofs[i], 32'h0);
            rchk(ofs[i], 0);
        end
        chk("all blocked", 0, pass);
        $display("t_masks done");
    endtask

    task t_codes;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_PRI_T1, {16'h0, 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]});
            chk("timer1 level", c, level[11:9]);
            chk("code pass", c ? 4'hF : 4'h0, pass[3:0]);
            chk("top level", c, top);
        end
        wr(OFS_PRI_T1, 32'h7531);
        chk("field order", {3'h7, 3'h5, 3'h3, 3'h1}, level[11:0]);
        $display("t_codes done");
    endtask

    task t_adc;
        wr(OFS_PRI_ADC, 32'h50);
        wr(OFS_ADC_EN, 32'h1);
        chk("pair2 only", 5'h01, pass[25:21]);
        chk("pair2 level", 5, level[65:63]);
        wr(OFS_ADC_EN, 32'h10);
        chk("pair6 only", 5'h10, pass[25:21]);
        wr(OFS_ADC_EN, 32'h1F);
        wr(OFS_PRI_ADC, 32'h0);
        chk("code off", 5'h00, pass[25:21]);
        wr(OFS_PRI_EXT2, 32'h60);
        chk("ext2 level", 6, level[44:42]);
        chk("ext2 pass", 1, pass[14]);
        $display("t_adc done");
    endtask

    task t_irq;
        wr(6'h2C, 32'h1);
        chk("unmapped write", RESP_SLVERR, r);
        rd(6'h02);
        chk("misaligned read", RESP_SLVERR, r);
        wr(OFS_INT_STAT, 32'h0);
        rchk(OFS_INT_STAT, 32'h3);
        chk("irq masked", 0, irq);
        wr(OFS_INT_EN, 32'h3);
        chk("irq on", 1, irq);
        wr(OFS_INT_CLR, 32'h1);
        rchk(OFS_INT_STAT, 32'h2);
        chk("irq read err", 1, irq);
        wr(OFS_INT_CLR, 32'h2);
        chk("irq off", 0, irq);
        $display("t_irq done");
    endtask

    task end_sim;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_masks();
        t_codes();
        t_adc();
        t_irq();
        end_sim();
    end
endmodule

// File: verification/prio_arbiter_model.sv
// Model of the arbiter beside the bank: picks the highest level allowed to request.
// Assumes the bank's registered per-source pass and level vectors.
`timescale 1ns/1ps
module prio_arbiter_model
    import prio_bank_pkg::*;
(
    // Per-source results from the bank
    input  wire logic [NUM_SRC-1:0]   pass_i,
    input  wire logic [NUM_SRC*3-1:0] level_i,
    // Winning level
    output logic [2:0]                top_o
);
    // Blocked sources never compete; the highest code wins
    always_comb begin
        top_o = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pass_i[i] && level_i[i*3+:3] > top_o) top_o = level_i[i*3+:3];
        end
    end
endmodule

// File: verification/prio_bank_sva.sv
// Checker for the priority bank, bound to the top module.
// Assumes only the top module's ports, one clock and synchronous reset.
`timescale 1ns/1ps
module prio_bank_sva
    import prio_bank_pkg::*;
(
    // Clock, reset and bus handshakes
    input wire logic                 CLK_I,
    input wire logic                 RESETN_I,
    input wire logic                 S_AXI_AWVALID_I,
    input wire logic                 S_AXI_AWREADY_O,
    input wire logic                 S_AXI_WVALID_I,
    input wire logic                 S_AXI_WREADY_O,
    input wire logic [1:0]           S_AXI_BRESP_O,
    input wire logic                 S_AXI_BVALID_O,
    input wire logic                 S_AXI_BREADY_I,
    input wire logic                 S_AXI_ARVALID_I,
    input wire logic                 S_AXI_ARREADY_O,
    input wire logic [31:0]          S_AXI_RDATA_O,
    input wire logic                 S_AXI_RVALID_O,
    input wire logic                 S_AXI_RREADY_I,
    // Per-source results
    input wire logic [NUM_SRC-1:0]   SRC_PASS_O,
    input wire logic [NUM_SRC*3-1:0] SRC_LEVEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    // Bus answers stand until taken, come on time and block new writes
    a_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped early");
    a_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped early");
    a_r_latency: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read answer late");
    a_b_latency: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O)
        else $error("write answer late");
    a_b_busy: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("new write accepted during response");
    // Register contents seen at the outputs
    a_r_upper: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0)
        else $error("read data upper half not zero");
    a_pass_code: assert property (SRC_PASS_O[0] == (SRC_LEVEL_O[2:0] != 3'h0))
        else $error("pass disagrees with code");
    a_unimpl_off: assert property (!SRC_PASS_O[4] && SRC_LEVEL_O[14:12] == 3'h0)
        else $error("unused field drives a source");
    a_adc_level: assert property (SRC_PASS_O[21] |-> SRC_LEVEL_O[65:63] == SRC_LEVEL_O[41:39] && SRC_LEVEL_O[41:39] != 3'h0)
        else $error("adc pair level wrong");
    a_ext2_slot: assert property (SRC_PASS_O[14] == (SRC_LEVEL_O[44:42] != 3'h0))
        else $error("ext line 2 pass disagrees with code");
endmodule

bind interrupt_priority_enable_bank prio_bank_sva prio_bank_sva_i (.*);
